/* rtl/cbg_glue.sv */
// cbg_glue: cpu-side glue forming converter select, read, write strobes.
// assumes cpu bus signals synchronous to clk_sys_i; converter data three-state.
`timescale 1ns/1ps
// How it works
// - converter select comes from decoding the cpu address here.
// - memory placement uses memory decode and memory read/write strobes.
// - io placement uses port strobes and low or high address byte decode.
// - cpu select, read, write may pass straight to the converter.
// - with at most eight io devices one low address bit is a select.
// - general strobes are gated with io or memory request.
// - io cycles on request-line cpus carry one extra wait state.
// - upper address byte during io input may be latched, e.g. mux channel.
// - single io/memory line replaces io request; inverted for io placement.
// - read/write-line cpus qualify select with valid address and phase two.
// - predecoded page line may drive select if 4xxx/5xxx unused elsewhere.
// - through a parallel adapter, select and read are held low.
module cbg_glue (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire cbg_pkg::cbg_mode_t mode_i,
   input wire logic [15:0] mem_base_i,
   input wire logic [7:0] port_addr_i,
   input wire logic use_high_byte_i,
   input wire logic direct_bit_sel_i,
   input wire logic [2:0] direct_bit_i,
   input wire cbg_pkg::cbg_cpu_t cpu_i,
   input wire logic [7:0] conv_data_i,
   input wire logic conversion_done_n_i,
   output cbg_pkg::cbg_conv_t conv_o,
   output logic [7:0] cpu_data_o,
   output logic cpu_data_oe_o,
   output logic [7:0] mux_channel_o,
   output logic restart_o,
   output logic busy_o
);
   import cbg_pkg::*;

   function automatic logic page_hit(input logic [15:0] a);
      page_hit = (a[15:12] == PAGE_4) || (a[15:12] == PAGE_5);
   endfunction

   // decodes
   wire logic mem_hit = (cpu_i.addr == mem_base_i);
   wire logic [7:0] io_byte = use_high_byte_i ? cpu_i.addr[15:8] : cpu_i.addr[7:0];
   wire logic io_hit_dec = (io_byte == port_addr_i);
   wire logic io_hit_bit = ~cpu_i.addr[direct_bit_i];
   wire logic io_hit = direct_bit_sel_i ? io_hit_bit : io_hit_dec;
   wire logic page_sel = ~cpu_i.predecoded_page_select_n & page_hit(cpu_i.addr);

   wire logic gen_rd = ~cpu_i.read_strobe_n;
   wire logic gen_wr = ~cpu_i.write_strobe_n;
   wire logic rw_rd = cpu_i.valid_memory_address & cpu_i.phase_two_clock & cpu_i.read_write_n;
   wire logic rw_wr = cpu_i.valid_memory_address & cpu_i.phase_two_clock & ~cpu_i.read_write_n;

   logic sel_c, rd_c, wr_c;
   always_comb begin
      sel_c = 1'b0;
      rd_c = 1'b0;
      wr_c = 1'b0;
      case (mode_i)
         CBG_MODE_SPLIT_IO: begin
            sel_c = io_hit;
            rd_c = ~cpu_i.port_read_strobe_n;
            wr_c = ~cpu_i.port_write_strobe_n;
         end
         CBG_MODE_SPLIT_MEM: begin
            sel_c = mem_hit;
            rd_c = ~cpu_i.memory_read_strobe_n;
            wr_c = ~cpu_i.memory_write_strobe_n;
         end
         CBG_MODE_REQ_IO: begin
            sel_c = io_hit & ~cpu_i.io_request_n;
            rd_c = gen_rd & ~cpu_i.io_request_n;
            wr_c = gen_wr & ~cpu_i.io_request_n;
         end
         CBG_MODE_REQ_MEM: begin
            sel_c = mem_hit & ~cpu_i.memory_request_n;
            rd_c = gen_rd & ~cpu_i.memory_request_n;
            wr_c = gen_wr & ~cpu_i.memory_request_n;
         end
         CBG_MODE_IOM: begin
            // low line means memory; the select line stands for io request
            sel_c = cpu_i.io_or_memory_select ? io_hit : mem_hit;
            rd_c = gen_rd;
            wr_c = gen_wr;
         end
         CBG_MODE_RW: begin
            sel_c = mem_hit & cpu_i.valid_memory_address;
            rd_c = rw_rd;
            wr_c = rw_wr;
         end
         CBG_MODE_PAGE: begin
            sel_c = page_sel & cpu_i.valid_memory_address;
            rd_c = rw_rd;
            wr_c = rw_wr;
         end
         CBG_MODE_PORT: begin
            sel_c = 1'b1;
            rd_c = 1'b1;
            wr_c = gen_wr;
         end
         default: begin
            sel_c = 1'b0;
         end
      endcase
   end

   // strobes only with decode; released one clock after the cpu strobe
   wire logic rd_act = sel_c & rd_c;
   wire logic wr_act = sel_c & wr_c;
   wire logic io_input = (mode_i == CBG_MODE_REQ_IO) & rd_act;

   logic sel_n_q, rd_n_q, wr_n_q, busy_q, wr_act_q, restart_q;
   logic [7:0] rd_cnt_q;
   logic [7:0] rd_cnt_d;
   logic [7:0] data_q;
   logic oe_q;
   logic done_n_q;
   // a done left low by an unread result must not clear a fresh start
   wire logic done_fall = done_n_q & ~conversion_done_n_i;

   assign rd_cnt_d = rd_act ? ((rd_cnt_q == 8'hff) ? rd_cnt_q : rd_cnt_q + 8'h01) : CNT_ZERO;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sel_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         wr_act_q <= 1'b0;
         busy_q <= 1'b0;
         restart_q <= 1'b0;
         rd_cnt_q <= CNT_ZERO;
         data_q <= DATA_RST;
         oe_q <= 1'b0;
         done_n_q <= 1'b1;
      end else begin
         sel_n_q <= ~(sel_c & (rd_c | wr_c)) & ~(mode_i == CBG_MODE_PORT);
         rd_n_q <= ~rd_act;
         wr_n_q <= ~wr_act;
         wr_act_q <= wr_act;
         // restart pulse when a start ends while the converter is busy
         restart_q <= wr_act_q & ~wr_act & busy_q;
         if (wr_act_q & ~wr_act) begin
            busy_q <= 1'b1;
         end else if (done_fall) begin
            busy_q <= 1'b0;
         end
         rd_cnt_q <= rd_cnt_d;
         done_n_q <= conversion_done_n_i;
         // converter drives three-state bus; capture after access time
         if (rd_act && rd_cnt_q == 8'(RD_ACCESS_CYC)) begin
            data_q <= conv_data_i;
         end
         oe_q <= rd_act && rd_cnt_q >= 8'(RD_ACCESS_CYC);
      end
   end

   cbg_hold_reg u_mux (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .load_i(io_input),
      .data_i(cpu_i.addr[15:8]),
      .data_o(mux_channel_o)
   );

   assign conv_o.converter_select_n = sel_n_q;
   assign conv_o.read_strobe_n = rd_n_q;
   assign conv_o.write_strobe_n = wr_n_q;
   assign cpu_data_o = data_q;
   assign cpu_data_oe_o = oe_q;
   assign restart_o = restart_q;
   assign busy_o = busy_q;

   AST_RD_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rd_act |=> !conv_o.read_strobe_n) else $error("read strobe not asserted");
   AST_RD_RELEASE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !rd_act |=> conv_o.read_strobe_n) else $error("read strobe not released");
   AST_WR_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wr_act |=> !conv_o.write_strobe_n) else $error("write strobe not asserted");
   AST_SEL_WITH_WR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !conv_o.write_strobe_n |-> !conv_o.converter_select_n) else $error("write without select");
   AST_PORT_LOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_PORT ##1 mode_i == CBG_MODE_PORT |-> !conv_o.converter_select_n
      && !conv_o.read_strobe_n) else $error("port mode lines not low");
   AST_REQ_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_REQ_IO && cpu_i.io_request_n |=> conv_o.read_strobe_n
      && conv_o.write_strobe_n) else $error("strobe without io request");
   AST_VMA_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_RW && !cpu_i.valid_memory_address |=> conv_o.converter_select_n)
      else $error("select without valid address");
   sequence s_start_end;
      wr_act ##1 !wr_act;
   endsequence
   AST_BUSY_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_start_end |=> busy_q) else $error("busy not set after start");
   AST_MUX_LATCH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      io_input |=> mux_channel_o == $past(cpu_i.addr[15:8])) else $error("mux not latched");
   // oe only once the converter has had its access time
   AST_OE_AFTER_ACCESS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rd_act && rd_cnt_q >= 8'(RD_ACCESS_CYC) |=> cpu_data_oe_o)
      else $error("data enable late");
   AST_OE_DROP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !rd_act |=> !cpu_data_oe_o) else $error("data enable held after read");
   AST_MEM_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_SPLIT_MEM && !mem_hit |=> conv_o.converter_select_n)
      else $error("select without memory decode");
   AST_IOM_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_IOM && !cpu_i.io_or_memory_select && !mem_hit
      |=> conv_o.converter_select_n) else $error("select without decode in iom mode");
   AST_PAGE_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      mode_i == CBG_MODE_PAGE && !page_hit(cpu_i.addr) |=> conv_o.converter_select_n)
      else $error("select outside page");
   sequence s_restart;
      wr_act ##1 (!wr_act && busy_q);
   endsequence
   AST_RESTART: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_restart |=> restart_o) else $error("no restart pulse");
   AST_RESTART_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      restart_o |=> !restart_o) else $error("restart pulse too long");
   AST_BUSY_CLEAR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      busy_q && done_fall && !(wr_act_q && !wr_act) |=> !busy_q)
      else $error("busy not cleared on done");
endmodule // cbg_glue

/* rtl/cbg_pkg.sv */
// cbg_pkg: constants and carriers for the converter bus glue.
// assumes one 100 MHz system clock and synchronous cpu-side inputs.
package cbg_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // converter output enable time after read strobe falls, ns
   localparam int RD_ACCESS_NS = 135;
   localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // least write strobe low width, ns
   localparam int WR_WIDTH_NS = 100;
   localparam int WR_WIDTH_CYC = (WR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   // page decode for the predecoded 4xxx/5xxx select
   localparam logic [3:0] PAGE_4 = 4'h4;
   localparam logic [3:0] PAGE_5 = 4'h5;
   localparam logic [7:0] PORT_ADDR_RST = 8'h00;
   localparam logic [15:0] MEM_ADDR_RST = 16'h4000;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] MUX_RST = 8'h00;
   localparam int SEL_LINES = 8;

   typedef enum logic [2:0] {
      CBG_MODE_SPLIT_IO,   // separate memory/io strobes, io space
      CBG_MODE_SPLIT_MEM,  // separate memory/io strobes, memory space
      CBG_MODE_REQ_IO,     // general strobes plus request lines, io space
      CBG_MODE_REQ_MEM,    // general strobes plus request lines, memory space
      CBG_MODE_IOM,        // general strobes plus one io/memory line
      CBG_MODE_RW,         // single read/write line with valid address
      CBG_MODE_PAGE,       // predecoded page line drives select
      CBG_MODE_PORT        // parallel adapter: select and read tied low
   } cbg_mode_t;

   typedef struct packed {
      logic [15:0] addr;
      logic memory_read_strobe_n;
      logic memory_write_strobe_n;
      logic port_read_strobe_n;
      logic port_write_strobe_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic memory_request_n;
      logic io_request_n;
      logic io_or_memory_select;
      logic read_write_n;
      logic valid_memory_address;
      logic phase_two_clock;
      logic predecoded_page_select_n;
   } cbg_cpu_t;

   typedef struct packed {
      logic converter_select_n;
      logic read_strobe_n;
      logic write_strobe_n;
   } cbg_conv_t;
endpackage

/* rtl/cbg_hold_reg.sv */
// cbg_hold_reg: small register that captures a byte on a strobe.
// assumes synchronous inputs; read data always come from the flop.
`timescale 1ns/1ps
module cbg_hold_reg (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o
);
   import cbg_pkg::*;
   logic [7:0] data_q;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_q <= DATA_RST;
      end else if (load_i) begin
         data_q <= data_i;
      end
   end

   assign data_o = data_q;
endmodule // cbg_hold_reg

/* tb/cbg_conv_model.sv */
// cbg_conv_model: behavioural 8-bit converter behind the glue's strobes.
// assumes strobes registered to clk_sys_i; result is RES_BASE plus start count.
`timescale 1ns/1ps
module cbg_conv_model #(
   parameter int CONV_CYC = 40,
   parameter logic [7:0] RES_BASE = 8'h3c
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire cbg_pkg::cbg_conv_t conv_i,
   output logic [7:0] data_o,
   output logic done_n_o
);
   import cbg_pkg::*;
   logic wr_q;
   logic [7:0] n_start_q;
   logic [7:0] latch_q;
   logic [7:0] last_q;
   int cnt_q;
   wire wr_act = !conv_i.converter_select_n && !conv_i.write_strobe_n;
   wire rd_act = !conv_i.converter_select_n && !conv_i.read_strobe_n;
   // released bus toggles so a stale byte never looks valid
   assign data_o = rd_act ? latch_q : ~last_q;
   always_ff @(posedge clk_sys_i) begin
      last_q <= data_o;
      if (rst_i) begin
         wr_q <= 1'b0;
         n_start_q <= 8'h00;
         latch_q <= 8'h00;
         cnt_q <= 0;
         done_n_o <= 1'b1;
      end else begin
         wr_q <= wr_act;
         if (rd_act) begin
            done_n_o <= 1'b1;
         end
         if (wr_q && !wr_act) begin
            n_start_q <= n_start_q + 8'h01;
            cnt_q <= CONV_CYC;
            done_n_o <= 1'b1;
         end else if (cnt_q == 1) begin
            latch_q <= RES_BASE + n_start_q;
            done_n_o <= 1'b0;
            cnt_q <= 0;
         end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule // cbg_conv_model

/* tb/converter_cpu_bus_glue_tb.sv */
// converter_cpu_bus_glue_tb: self-checking bench for cbg_glue.
// assumes cbg_conv_model as the converter; cpu flags toggled from an idle word.
`timescale 1ns/1ps
module converter_cpu_bus_glue_tb;
   import cbg_pkg::*;
   localparam logic [15:0] MEM_A = 16'h4a10;
   localparam logic [7:0] PORT_A = 8'h6c;
   localparam logic [15:0] IO_A = {8'ha5, PORT_A};
   localparam logic [7:0] RES_BASE = 8'h3c;
   // flag masks over the low 13 bits of cbg_cpu_t; xor with IDLE activates
   localparam logic [12:0] IDLE = 13'h1fe9, F_MRD = 13'h1000, F_MWR = 13'h0800,
      F_PRD = 13'h0400, F_PWR = 13'h0200, F_RD = 13'h0100, F_WR = 13'h0080,
      F_MRQ = 13'h0040, F_IRQ = 13'h0020, F_IOM = 13'h0010, F_RWN = 13'h0008,
      F_VA = 13'h0004, F_P2 = 13'h0002, F_PG = 13'h0001;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   cbg_mode_t mode = CBG_MODE_SPLIT_IO;
   logic use_high = 1'b0;
   logic bit_sel = 1'b0;
   cbg_cpu_t cpu = {16'h0000, IDLE};
   wire [7:0] conv_data;
   wire done_n;
   cbg_conv_t conv;
   logic [7:0] cpu_data;
   logic [7:0] mux;
   logic oe, restart, busy;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_conv = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   cbg_glue dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_i(mode), .mem_base_i(MEM_A),
      .port_addr_i(PORT_A), .use_high_byte_i(use_high), .direct_bit_sel_i(bit_sel),
      .direct_bit_i(3'h3), .cpu_i(cpu), .conv_data_i(conv_data), .conversion_done_n_i(done_n),
      .conv_o(conv), .cpu_data_o(cpu_data), .cpu_data_oe_o(oe), .mux_channel_o(mux),
      .restart_o(restart), .busy_o(busy));
   cbg_conv_model #(.CONV_CYC(40), .RES_BASE(RES_BASE)) model_u (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .conv_i(conv), .data_o(conv_data), .done_n_o(done_n));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk1(logic got, logic exp, string msg);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %b", $time, msg, got);
      end
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp, string msg);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic wait_done();
      int i;
      i = 0;
      while (done_n !== 1'b0 && i < 200) begin
         @(posedge clk_sys_i);
         i++;
      end
      if (done_n !== 1'b0) begin
         chk1(1'b0, 1'b1, "no conversion done");
         print_verdict();
      end
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk1(busy, 1'b0, "busy after done");
   endtask
   task automatic pulse(cbg_mode_t m, logic [15:0] a, logic [12:0] t, logic hit);
      @(posedge clk_sys_i);
      mode <= m;
      cpu <= {a, IDLE ^ t};
      repeat (WR_WIDTH_CYC) @(posedge clk_sys_i);
      #1;
      chk1(conv.converter_select_n, !hit, "select");
      chk1(conv.write_strobe_n, !hit, "write strobe");
      @(posedge clk_sys_i);
      cpu <= {a, IDLE};
      if (hit) n_conv++;
   endtask
   // one write per placement style; miss cases must leave the converter alone
   task automatic wr_case(cbg_mode_t m, logic [15:0] a, logic [12:0] t, logic hit);
      pulse(m, a, t, hit);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk1(conv.write_strobe_n, 1'b1, "write release");
      chk1(busy, hit, "busy after start");
      if (hit) wait_done();
      $display("test write mode %0d done", m);
   endtask
   task automatic t_read(cbg_mode_t m, logic [15:0] a, logic [12:0] t, logic [7:0] exp,
      logic [7:0] exp_mux);
      @(posedge clk_sys_i);
      mode <= m;
      cpu <= {a, IDLE ^ t};
      repeat (RD_ACCESS_CYC + 4) @(posedge clk_sys_i);
      // request-line cpus stretch io strobes by one wait state
      if (m == CBG_MODE_REQ_IO) @(posedge clk_sys_i);
      #1;
      chk1(conv.read_strobe_n, 1'b0, "read strobe");
      chk1(oe, 1'b1, "data enable");
      @(posedge clk_sys_i);
      cpu <= {a, IDLE};
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk8(cpu_data, exp, "read data");
      chk8(mux, exp_mux, "mux channel");
      chk1(conv.read_strobe_n, 1'b1, "read release");
      $display("test read mode %0d done", m);
   endtask
   task automatic t_restart();
      logic seen;
      seen = 1'b0;
      pulse(CBG_MODE_SPLIT_MEM, MEM_A, F_MWR, 1'b1);
      pulse(CBG_MODE_SPLIT_MEM, MEM_A, F_MWR, 1'b1);
      repeat (6) begin
         @(posedge clk_sys_i);
         #1;
         if (restart === 1'b1) seen = 1'b1;
      end
      chk1(seen, 1'b1, "restart pulse");
      t_read(CBG_MODE_REQ_IO, IO_A, F_RD | F_IRQ, RES_BASE + 8'(n_conv - 2), 8'ha5);
      wait_done();
      t_read(CBG_MODE_REQ_IO, IO_A, F_RD | F_IRQ, RES_BASE + 8'(n_conv), 8'ha5);
      $display("test restart done");
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      chk1(conv.converter_select_n, 1'b1, "reset select");
      chk1(busy | restart | oe, 1'b0, "reset flags");
      wr_case(CBG_MODE_SPLIT_MEM, MEM_A, F_MWR, 1'b1);
      wr_case(CBG_MODE_SPLIT_MEM, 16'h4a11, F_MWR, 1'b0);
      wr_case(CBG_MODE_SPLIT_IO, {8'h00, PORT_A}, F_PWR, 1'b1);
      wr_case(CBG_MODE_SPLIT_IO, 16'h006d, F_PWR, 1'b0);
      use_high <= 1'b1;
      wr_case(CBG_MODE_SPLIT_IO, {PORT_A, 8'h00}, F_PWR, 1'b1);
      use_high <= 1'b0;
      bit_sel <= 1'b1;
      wr_case(CBG_MODE_SPLIT_IO, 16'hfff7, F_PWR, 1'b1);
      wr_case(CBG_MODE_SPLIT_IO, 16'hffff, F_PWR, 1'b0);
      bit_sel <= 1'b0;
      wr_case(CBG_MODE_REQ_IO, {8'h00, PORT_A}, F_WR | F_IRQ, 1'b1);
      wr_case(CBG_MODE_REQ_IO, {8'h00, PORT_A}, F_WR | F_MRQ, 1'b0);
      wr_case(CBG_MODE_REQ_MEM, MEM_A, F_WR | F_MRQ, 1'b1);
      wr_case(CBG_MODE_IOM, {8'h00, PORT_A}, F_WR | F_IOM, 1'b1);
      wr_case(CBG_MODE_IOM, MEM_A, F_WR, 1'b1);
      wr_case(CBG_MODE_RW, MEM_A, F_RWN | F_VA | F_P2, 1'b1);
      wr_case(CBG_MODE_RW, MEM_A, F_RWN | F_P2, 1'b0);
      wr_case(CBG_MODE_PAGE, 16'h5123, F_PG | F_RWN | F_VA | F_P2 | F_WR, 1'b1);
      wr_case(CBG_MODE_PAGE, 16'h6123, F_PG | F_RWN | F_VA | F_P2 | F_WR, 1'b0);
      t_read(CBG_MODE_SPLIT_IO, IO_A, F_PRD, RES_BASE + 8'(n_conv), MUX_RST);
      t_read(CBG_MODE_SPLIT_MEM, MEM_A, F_MRD, RES_BASE + 8'(n_conv), MUX_RST);
      t_restart();
      @(posedge clk_sys_i);
      mode <= CBG_MODE_PORT;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk1(conv.converter_select_n | conv.read_strobe_n, 1'b0, "adapter tie");
      print_verdict();
   end
endmodule // converter_cpu_bus_glue_tb
